// File: spcs_pkg.sv
// package: register map, field positions, rate constants and state types of the serial port
package spcs_pkg;
  localparam int SPCS_AW = 8;
  localparam logic [7:0] SPCS_TXCTL_OFF = 8'h00;
  localparam logic [7:0] SPCS_RXCTL_OFF = 8'h04;
  localparam logic [7:0] SPCS_BAUD_OFF = 8'h08;
  localparam logic [7:0] SPCS_DIVLO_OFF = 8'h0c;
  localparam logic [7:0] SPCS_DIVHI_OFF = 8'h10;
  localparam logic [7:0] SPCS_RXDATA_OFF = 8'h14;
  localparam logic [7:0] SPCS_TXDATA_OFF = 8'h18;
  // transmit control/status fields
  localparam int SPCS_TX_CLOCK_SOURCE_SELECT = 7;
  localparam int SPCS_TX_TX9 = 6;
  localparam int SPCS_TX_TRANSMIT_ENABLE_BIT = 5;
  localparam int SPCS_TX_SYNC = 4;
  localparam int SPCS_TX_BREAK_REQUEST = 3;
  localparam int SPCS_TX_HIGH_SPEED_SELECT = 2;
  localparam int SPCS_TX_SHIFTER_EMPTY_FLAG = 1;
  localparam int SPCS_TX_TX_NINTH_BIT = 0;
  // receive control/status fields
  localparam int SPCS_RX_PORT_ENABLE = 7;
  localparam int SPCS_RX_RX9 = 6;
  localparam int SPCS_RX_SINGLE_RECEIVE_ENABLE = 5;
  localparam int SPCS_RX_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int SPCS_RX_ADDRESS_DETECT_ENABLE = 3;
  // baud control fields
  localparam int SPCS_BC_AUTOBAUD_OVERFLOW_FLAG = 7;
  localparam int SPCS_BC_POLARITY_SELECT = 4;
  localparam int SPCS_BC_GENERATOR_WIDTH_SELECT = 3;
  localparam int SPCS_BC_WUE = 1;
  localparam int SPCS_BC_AUTOBAUD_ENABLE = 0;
  localparam logic [7:0] SPCS_BAUD_WMASK = 8'h1b;
  // ticks of the baud generator per bit
  localparam logic [6:0] SPCS_PRE_SLOW = 7'h40;
  localparam logic [6:0] SPCS_PRE_MID = 7'h10;
  localparam logic [6:0] SPCS_PRE_FAST = 7'h04;
  localparam logic [3:0] SPCS_NB8 = 4'h8;
  localparam logic [3:0] SPCS_NB9 = 4'h9;
  localparam logic [3:0] SPCS_BRK_BITS = 4'hc;
  localparam logic [2:0] SPCS_ABD_FALLS = 3'h4;
  // buffered word: {framing error, ninth bit, data}
  localparam int SPCS_HD_W = 10;
  localparam int SPCS_HD_FRAMING_ERROR_FLAG = 9;
  localparam int SPCS_HD_B9 = 8;
  typedef enum logic [3:0] {
    SPCS_RX_IDLE = 4'b0001, SPCS_RX_START = 4'b0010, SPCS_RX_DATA = 4'b0100, SPCS_RX_STOP = 4'b1000
  } spcs_rx_st_t;
  typedef enum logic [3:0] {
    SPCS_TX_IDLE = 4'b0001, SPCS_TX_START = 4'b0010, SPCS_TX_DATA = 4'b0100, SPCS_TX_STOP = 4'b1000
  } spcs_tx_st_t;
  typedef enum logic [2:0] {
    SPCS_SY_IDLE = 3'b001, SPCS_SY_XFER = 3'b010, SPCS_SY_LAST = 3'b100
  } spcs_sy_st_t;
endpackage

// File: spcs_rx_fifo.sv
// module: small receive character buffer with a registered head word
`timescale 1ns/1ps
module spcs_rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic full,
  output logic head_valid_q,
  output logic [WIDTH-1:0] head_q
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic empty;
  logic do_push;
  logic do_pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign full = (count_q == CW'(DEPTH));
  assign empty = (count_q == '0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (clr) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) wr_ptr_q <= bump(wr_ptr_q);
      if (do_pop) rd_ptr_q <= bump(rd_ptr_q);
      if (do_push && !do_pop) count_q <= count_q + CW'(1);
      else if (do_pop && !do_push) count_q <= count_q - CW'(1);
    end
  end

  // storage needs no reset; head and valid lag the pointers by one cycle together
  always_ff @(posedge clk) begin
    if (do_push) mem_q[wr_ptr_q] <= push_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_q <= '0;
      head_valid_q <= 1'b0;
    end else begin
      head_q <= mem_q[rd_ptr_q];
      head_valid_q <= !empty && !clr;
    end
  end
endmodule

// File: spcs_port.sv
// module: registers, baud generator and serial engines of the combined async/sync serial port
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
// Functional notes
// - sync mode: clock source bit set makes us clock master, clear makes us slave
// - tx nine-bit select picks 9 or 8 bit characters; ninth bit from register
// - async break request sends a break on next transmission, cleared when done
// - shifter empty flag is read-only, 1 when transmit shifter empty, resets to 1
// - sync mode: continuous receive, and single receive when master, take priority over transmit enable
// - port enable routes the pins to the port; clear holds the port in reset
// - rx nine-bit select makes the receiver shift 9 or 8 bits
// - sync master: single receive does one character, then hardware clears it
// - continuous receive switches async receiver; in sync it runs and overrides single
// - 9-bit async with address detect: only characters with ninth bit 1 are kept
// - without address detect every character kept; 8-bit mode ignores address detect
// - framing flag read-only, changes only as buffered characters are read and arrive, or when port enable is cleared
// - overrun flag read-only, cleared by clearing continuous receive
// - received ninth bit is shown unchecked; parity is left to firmware
// - async auto-baud overflow flag shows the auto-baud timer wrapped
// - receiver idle flag 1 when idle, 0 from start bit to end, resets to 1
// - polarity: async inverts transmit pin data; sync picks the clocking edge
// - generator width picks 16 or 8 bit divisor; high speed bit sets async rate
// - wake-up: wait for falling edge only, set receive flag, then clear itself
// - auto-baud enable starts rate detection; hardware clears it when complete
// - two-character buffer; a third full character sets overrun and stops reception
// - start bit rechecked at half bit, abandoned silently if high; majority sampling
// - each buffered character keeps its framing status; flag shows the oldest
module spcs_port #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [spcs_pkg::SPCS_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxdt_in,
  output logic rxdt_out,
  output logic rxdt_oe,
  input wire logic txck_in,
  output logic txck_out,
  output logic txck_oe,
  output logic rx_flag
);
  import spcs_pkg::*;

  function automatic logic [6:0] prescale(input logic syn, input logic w16, input logic hs);
    if (syn || (w16 && hs)) prescale = SPCS_PRE_FAST;
    else if (w16 || hs) prescale = SPCS_PRE_MID;
    else prescale = SPCS_PRE_SLOW;
  endfunction

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  logic clock_source_select_q, tx9_q, transmit_enable_bit_q, sync_q, break_request_q, high_speed_select_q, tx_ninth_bit_q;
  logic port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q, overrun_error_flag_q;
  logic autobaud_overflow_flag_q, polarity_select_q, generator_width_select_q, wue_q, autobaud_enable_q, wake_q;
  logic [15:0] div_q;
  logic [15:0] brg_q;
  logic [7:0] txbuf_q;
  logic txbuf_full_q, rx_prev_q, ck_prev_q;
  spcs_rx_st_t rx_st_q, rx_st_d;
  spcs_tx_st_t tx_st_q, tx_st_d;
  spcs_sy_st_t sy_st_q;
  logic [6:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, sy_cnt_q;
  logic [3:0] rx_bit_q, rx_bit_d, tx_bit_q, sy_bit_q;
  logic [8:0] rsr_q, rsr_d, tsr_q, sy_sr_q;
  logic [1:0] vote_q;
  logic brk_q, sy_rx_q, sy_pend_q, abd_run_q;
  logic [2:0] abd_falls_q;
  logic [9:0] abd_pre_q;
  logic [15:0] abd_cnt_q;
  logic [SPCS_HD_W-1:0] head_q;
  logic head_valid_q;

  // bus decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire sel_tx = (paddr == SPCS_TXCTL_OFF);
  wire sel_rx = (paddr == SPCS_RXCTL_OFF);
  wire sel_bc = (paddr == SPCS_BAUD_OFF);
  wire sel_dl = (paddr == SPCS_DIVLO_OFF);
  wire sel_dh = (paddr == SPCS_DIVHI_OFF);
  wire sel_rd = (paddr == SPCS_RXDATA_OFF);
  wire sel_td = (paddr == SPCS_TXDATA_OFF);
  wire mapped = sel_tx | sel_rx | sel_bc | sel_dl | sel_dh | sel_rd | sel_td;
  wire div_wr = wr_en && (sel_dl || sel_dh);
  wire rxdata_rd = rd_en && sel_rd;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // shared timing
  wire [6:0] pre = prescale(sync_q, generator_width_select_q, high_speed_select_q);
  wire [6:0] half = pre >> 1;
  wire [15:0] brg_reload = generator_width_select_q ? div_q : {8'h00, div_q[7:0]};
  wire brg_tick = (brg_q == 16'h0000);
  wire rx_fall = rx_prev_q && !rxdt_in;
  wire async_on = port_enable_q && !sync_q;
  wire sy_on = port_enable_q && sync_q;

  // async receiver
  wire rx_on = async_on && continuous_receive_enable_q && !overrun_error_flag_q && !wue_q && !autobaud_enable_q;
  wire [3:0] nb_rx = rx9_q ? SPCS_NB9 : SPCS_NB8;
  wire rx_bitval = maj3(vote_q[1], vote_q[0], rxdt_in);
  wire rx_end = brg_tick && (rx_cnt_q == pre - 7'h01);
  wire a_done = (rx_st_q == SPCS_RX_STOP) && rx_end && rx_on;
  wire [8:0] a_word = rx9_q ? rsr_q : {1'b0, rsr_q[8:1]};
  wire a_keep = !(rx9_q && address_detect_enable_q) || rsr_q[8];

  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = brg_tick ? rx_cnt_q + 7'h01 : rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rsr_d = rsr_q;
    case (rx_st_q)
      SPCS_RX_IDLE: begin
        rx_cnt_d = '0;
        if (rx_on && rx_fall) rx_st_d = SPCS_RX_START;
      end
      SPCS_RX_START: if (brg_tick && rx_cnt_q == half - 7'h01) begin
        rx_cnt_d = '0;
        rx_bit_d = '0;
        rx_st_d = rxdt_in ? SPCS_RX_IDLE : SPCS_RX_DATA;
      end
      SPCS_RX_DATA: if (rx_end) begin
        rx_cnt_d = '0;
        rsr_d = {rx_bitval, rsr_q[8:1]};
        rx_bit_d = rx_bit_q + 4'h1;
        if (rx_bit_q == nb_rx - 4'h1) rx_st_d = SPCS_RX_STOP;
      end
      SPCS_RX_STOP: if (rx_end) rx_st_d = SPCS_RX_IDLE;
      default: rx_st_d = SPCS_RX_IDLE;
    endcase
    if (!rx_on) rx_st_d = SPCS_RX_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= SPCS_RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rsr_q <= '0;
      vote_q <= '0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rsr_q <= rsr_d;
      if (brg_tick) vote_q <= {vote_q[0], rxdt_in};
    end
  end

  // async transmitter
  wire tx_on = async_on && transmit_enable_bit_q;
  wire tx_end = brg_tick && (tx_cnt_q == pre - 7'h01);
  wire [3:0] nb_tx = brk_q ? SPCS_BRK_BITS : (tx9_q ? SPCS_NB9 : SPCS_NB8);
  wire tx_load = (tx_st_q == SPCS_TX_IDLE) && tx_on && txbuf_full_q;
  wire brk_done = (tx_st_q == SPCS_TX_STOP) && tx_end && brk_q;
  wire tx_line = (tx_st_q == SPCS_TX_START) ? 1'b0 :
                 (tx_st_q == SPCS_TX_DATA) ? (tsr_q[0] && !brk_q) : 1'b1;

  always_comb begin
    tx_st_d = tx_st_q;
    case (tx_st_q)
      SPCS_TX_IDLE: if (tx_load) tx_st_d = SPCS_TX_START;
      SPCS_TX_START: if (tx_end) tx_st_d = SPCS_TX_DATA;
      SPCS_TX_DATA: if (tx_end && tx_bit_q == nb_tx - 4'h1) tx_st_d = SPCS_TX_STOP;
      SPCS_TX_STOP: if (tx_end) tx_st_d = SPCS_TX_IDLE;
      default: tx_st_d = SPCS_TX_IDLE;
    endcase
    if (!tx_on) tx_st_d = SPCS_TX_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= SPCS_TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tsr_q <= '0;
      brk_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= (tx_st_q == SPCS_TX_IDLE || tx_end) ? '0 : tx_cnt_q + (brg_tick ? 7'h01 : 7'h00);
      if (tx_load) begin
        tsr_q <= {tx_ninth_bit_q, txbuf_q};
        brk_q <= break_request_q;
        tx_bit_q <= '0;
      end else if (tx_st_q == SPCS_TX_DATA && tx_end) begin
        tsr_q <= {1'b0, tsr_q[8:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
      end
    end
  end

  // synchronous engine: receive requests outrank transmit
  wire sy_rx_req = continuous_receive_enable_q || (single_receive_enable_q && clock_source_select_q);
  wire sy_start_rx = sy_rx_req && !overrun_error_flag_q;
  wire sy_start_tx = !sy_rx_req && transmit_enable_bit_q && txbuf_full_q;
  wire sy_idle = (sy_st_q == SPCS_SY_IDLE);
  wire sy_go = sy_on && sy_idle && (sy_start_rx || sy_start_tx);
  wire [3:0] nb_sy = (sy_rx_q ? rx9_q : tx9_q) ? SPCS_NB9 : SPCS_NB8;
  wire sy_xfer = (sy_st_q == SPCS_SY_XFER);
  wire ck_rise = !ck_prev_q && txck_in;
  wire ck_fall = ck_prev_q && !txck_in;
  // master samples at mid-bit, slave samples on the edge the polarity picks
  wire sy_smp = sy_xfer && (clock_source_select_q ? (brg_tick && sy_cnt_q == half - 7'h01) : (polarity_select_q ? ck_rise : ck_fall));
  wire sy_drv = sy_xfer && (clock_source_select_q ? (brg_tick && sy_cnt_q == pre - 7'h01) : (polarity_select_q ? ck_fall : ck_rise));
  wire sy_last = (sy_st_q == SPCS_SY_LAST);
  wire sy_single_done = sy_last && sy_rx_q && !continuous_receive_enable_q;
  wire [8:0] sy_word = (nb_sy == SPCS_NB9) ? sy_sr_q : {1'b0, sy_sr_q[8:1]};
  wire ck_lvl = (sy_xfer && clock_source_select_q && sy_cnt_q >= half) ^ !polarity_select_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy_st_q <= SPCS_SY_IDLE;
      sy_rx_q <= 1'b0;
      sy_cnt_q <= '0;
      sy_bit_q <= '0;
      sy_sr_q <= '0;
      sy_pend_q <= 1'b0;
    end else if (!sy_on) begin
      sy_st_q <= SPCS_SY_IDLE;
    end else begin
      case (sy_st_q)
        SPCS_SY_IDLE: if (sy_go) begin
          sy_st_q <= SPCS_SY_XFER;
          sy_rx_q <= sy_start_rx;
          sy_cnt_q <= '0;
          sy_bit_q <= '0;
          sy_pend_q <= 1'b0;
          sy_sr_q <= {tx_ninth_bit_q, txbuf_q};
        end
        SPCS_SY_XFER: begin
          if (brg_tick) sy_cnt_q <= (sy_cnt_q == pre - 7'h01) ? '0 : sy_cnt_q + 7'h01;
          if (sy_smp) begin
            sy_bit_q <= sy_bit_q + 4'h1;
            sy_pend_q <= !sy_rx_q;
            if (sy_rx_q) sy_sr_q <= {rxdt_in, sy_sr_q[8:1]};
            if (sy_bit_q == nb_sy - 4'h1) sy_st_q <= SPCS_SY_LAST;
          end else if (sy_drv && sy_pend_q) begin
            sy_sr_q <= {1'b0, sy_sr_q[8:1]};
            sy_pend_q <= 1'b0;
          end
        end
        SPCS_SY_LAST: sy_st_q <= SPCS_SY_IDLE;
        default: sy_st_q <= SPCS_SY_IDLE;
      endcase
    end
  end

  // receive buffer
  wire push_req = (a_done && a_keep) || (sy_last && sy_rx_q);
  wire fifo_full;
  wire ovf_ev = push_req && fifo_full;
  wire [SPCS_HD_W-1:0] push_word = a_done ? {!rx_bitval, a_word} : {1'b0, sy_word};

  spcs_rx_fifo #(.WIDTH(SPCS_HD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .clr(!port_enable_q),
    .push(push_req && !overrun_error_flag_q),
    .push_data(push_word),
    .pop(rxdata_rd),
    .full(fifo_full),
    .head_valid_q(head_valid_q),
    .head_q(head_q)
  );

  // auto-baud: five falling edges of a 0x55 character span eight bit times
  wire abd_act = async_on && autobaud_enable_q;
  wire [9:0] abd_scale = {pre, 3'b000};
  wire abd_wrap = abd_run_q && (abd_pre_q == abd_scale - 10'h001);
  wire abd_done = abd_run_q && rx_fall && (abd_falls_q == SPCS_ABD_FALLS - 3'h1);
  wire abd_ovf_ev = abd_wrap && (abd_cnt_q == 16'hffff);
  wire wake_ev = async_on && wue_q && rx_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abd_run_q <= 1'b0;
      abd_falls_q <= '0;
      abd_pre_q <= '0;
      abd_cnt_q <= '0;
    end else if (!abd_act || abd_done) begin
      abd_run_q <= 1'b0;
    end else if (!abd_run_q) begin
      abd_run_q <= rx_fall;
      abd_falls_q <= '0;
      abd_pre_q <= '0;
      abd_cnt_q <= '0;
    end else begin
      if (rx_fall) abd_falls_q <= abd_falls_q + 3'h1;
      abd_pre_q <= abd_wrap ? '0 : abd_pre_q + 10'h001;
      if (abd_wrap) abd_cnt_q <= abd_cnt_q + 16'h0001;
    end
  end

  // baud generator restarts on a divisor write so a new rate applies at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) brg_q <= '0;
    else if (!port_enable_q || div_wr) brg_q <= '0;
    else brg_q <= brg_tick ? brg_reload : brg_q - 16'h0001;
  end

  // software registers; a software set outranks a same-cycle hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {clock_source_select_q, tx9_q, transmit_enable_bit_q, sync_q, high_speed_select_q, tx_ninth_bit_q} <= '0;
      {port_enable_q, rx9_q, continuous_receive_enable_q, address_detect_enable_q, polarity_select_q, generator_width_select_q} <= '0;
      div_q <= '0;
    end else begin
      if (wr_en && sel_tx) begin
        clock_source_select_q <= pwdata[SPCS_TX_CLOCK_SOURCE_SELECT];
        tx9_q <= pwdata[SPCS_TX_TX9];
        transmit_enable_bit_q <= pwdata[SPCS_TX_TRANSMIT_ENABLE_BIT];
        sync_q <= pwdata[SPCS_TX_SYNC];
        high_speed_select_q <= pwdata[SPCS_TX_HIGH_SPEED_SELECT];
        tx_ninth_bit_q <= pwdata[SPCS_TX_TX_NINTH_BIT];
      end
      if (wr_en && sel_rx) begin
        port_enable_q <= pwdata[SPCS_RX_PORT_ENABLE];
        rx9_q <= pwdata[SPCS_RX_RX9];
        continuous_receive_enable_q <= pwdata[SPCS_RX_CONTINUOUS_RECEIVE_ENABLE];
        address_detect_enable_q <= pwdata[SPCS_RX_ADDRESS_DETECT_ENABLE];
      end
      if (wr_en && sel_bc) begin
        polarity_select_q <= pwdata[SPCS_BC_POLARITY_SELECT];
        generator_width_select_q <= pwdata[SPCS_BC_GENERATOR_WIDTH_SELECT];
      end
      if (wr_en && sel_dl) div_q[7:0] <= pwdata[7:0];
      else if (wr_en && sel_dh) div_q[15:8] <= pwdata[7:0];
      else if (abd_done) div_q <= (abd_cnt_q == 16'h0000) ? 16'h0000 : abd_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {break_request_q, single_receive_enable_q, wue_q, autobaud_enable_q, autobaud_overflow_flag_q, overrun_error_flag_q, wake_q, txbuf_full_q} <= '0;
      txbuf_q <= '0;
    end else begin
      if (wr_en && sel_tx) break_request_q <= pwdata[SPCS_TX_BREAK_REQUEST];
      else if (brk_done) break_request_q <= 1'b0;
      if (wr_en && sel_rx) single_receive_enable_q <= pwdata[SPCS_RX_SINGLE_RECEIVE_ENABLE];
      else if (sy_single_done) single_receive_enable_q <= 1'b0;
      if (wr_en && sel_bc) wue_q <= pwdata[SPCS_BC_WUE];
      else if (wake_ev) wue_q <= 1'b0;
      if (wr_en && sel_bc) autobaud_enable_q <= pwdata[SPCS_BC_AUTOBAUD_ENABLE];
      else if (abd_done) autobaud_enable_q <= 1'b0;
      if (abd_ovf_ev) autobaud_overflow_flag_q <= 1'b1;
      else if (wr_en && sel_bc && pwdata[SPCS_BC_AUTOBAUD_ENABLE]) autobaud_overflow_flag_q <= 1'b0;
      if (ovf_ev) overrun_error_flag_q <= 1'b1;
      else if (!continuous_receive_enable_q || !port_enable_q) overrun_error_flag_q <= 1'b0;
      if (wake_ev) wake_q <= 1'b1;
      else if (rxdata_rd || !port_enable_q) wake_q <= 1'b0;
      if (wr_en && sel_td) txbuf_q <= pwdata[7:0];
      if (wr_en && sel_td) txbuf_full_q <= 1'b1;
      else if (tx_load || (sy_go && sy_start_tx) || !port_enable_q) txbuf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_q <= 1'b1;
      ck_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rxdt_in;
      ck_prev_q <= txck_in;
    end
  end

  // status and read mux
  wire shifter_empty_flag = (tx_st_q == SPCS_TX_IDLE) && !(!sy_idle && !sy_rx_q);
  wire receiver_idle_flag = (rx_st_q == SPCS_RX_IDLE);
  wire framing_error_flag = head_valid_q && head_q[SPCS_HD_FRAMING_ERROR_FLAG];
  wire rx_ninth_bit = head_valid_q && head_q[SPCS_HD_B9];
  wire [7:0] tx_rd = {clock_source_select_q, tx9_q, transmit_enable_bit_q, sync_q, break_request_q, high_speed_select_q, shifter_empty_flag, tx_ninth_bit_q};
  wire [7:0] rx_rd = {port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q, framing_error_flag, overrun_error_flag_q, rx_ninth_bit};
  wire [7:0] bc_rd = {autobaud_overflow_flag_q, receiver_idle_flag, 1'b0, polarity_select_q, generator_width_select_q, 1'b0, wue_q, autobaud_enable_q} & (SPCS_BAUD_WMASK | 8'hc0);
  wire [7:0] rd_byte = sel_tx ? tx_rd : sel_rx ? rx_rd : sel_bc ? bc_rd : sel_dl ? div_q[7:0] :
                       sel_dh ? div_q[15:8] : sel_rd ? head_q[7:0] : 8'h00;
  assign prdata = {24'h000000, rd_byte};

  // pins
  assign txck_out = sync_q ? ck_lvl : (tx_line ^ polarity_select_q);
  assign txck_oe = port_enable_q && (!sync_q || clock_source_select_q);
  assign rxdt_out = sy_sr_q[0];
  assign rxdt_oe = sy_on && sy_xfer && !sy_rx_q;
  assign rx_flag = head_valid_q || wake_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_false_start;
    (rx_st_q == SPCS_RX_START) && brg_tick && (rx_cnt_q == half - 7'h01) && rxdt_in && rx_on;
  endsequence

  AST_FALSE_START: assert property (s_false_start |=> (rx_st_q == SPCS_RX_IDLE) && !push_req)
    else $error("false start bit not abandoned");
  AST_BREAK_LOW: assert property ((tx_st_q == SPCS_TX_DATA) && brk_q && async_on |-> txck_out == polarity_select_q)
    else $error("break did not hold the line low");
  AST_IDLE_LEVEL: assert property (async_on && (tx_st_q == SPCS_TX_IDLE) |-> txck_out == !polarity_select_q)
    else $error("idle transmit level ignores polarity");
  AST_ADDR_DROP: assert property (a_done && rx9_q && address_detect_enable_q && !rsr_q[8] |-> !push_req)
    else $error("non-address character was buffered");
  AST_OVERRUN: assert property (push_req && fifo_full && !overrun_error_flag_q |=> overrun_error_flag_q ##1 (overrun_error_flag_q || !continuous_receive_enable_q || !port_enable_q))
    else $error("overrun not flagged");
  AST_OVERRUN_ERROR_FLAG_CLR: assert property (!continuous_receive_enable_q && !single_receive_enable_q && !push_req |=> !overrun_error_flag_q)
    else $error("overrun survived continuous receive off");
  AST_IDLE_DROP: assert property (rx_on && receiver_idle_flag && rx_fall |=> !receiver_idle_flag [*2])
    else $error("receiver idle flag did not drop on start bit");
  AST_WAKE: assert property (wake_ev && !(wr_en && sel_bc) |=> !wue_q && rx_flag)
    else $error("wake-up edge did not set flag and clear enable");
  AST_PORT_OFF: assert property (!port_enable_q |-> !rxdt_oe && !txck_oe ##1 (sy_st_q == SPCS_SY_IDLE))
    else $error("disabled port still active");
  AST_SHIFTER_EMPTY_FLAG_LOAD: assert property (tx_load |=> !shifter_empty_flag)
    else $error("shifter empty flag set while loaded");
endmodule

// File: spcs_peer.sv
// remote asynchronous transmitter that drives the receive pin
`timescale 1ns/1ps
module spcs_peer #(
  parameter int BIT = 4
) (
  input wire logic pclk,
  input wire logic tx_pin,
  output logic line
);
  initial line = 1'b1;
  // call right after a rising edge; the line idles high, as a pulled-up serial line does
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    for (int i = 0; i < nb + 4; i++) begin
      line <= (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == nb + 1) ? stop : 1'b1;
      repeat (BIT) @(posedge pclk);
    end
  endtask
  // one-cycle low pulse: a false start that the receiver must drop without a character
  task automatic blip();
    line <= 1'b0;
    @(posedge pclk);
    line <= 1'b1;
    repeat (2 * BIT) @(posedge pclk);
  endtask
  // waits for a start bit on the port's transmit pin and samples every bit at mid-bit;
  // inv undoes the async polarity inversion, bits past the stop bit stay at idle ones
  task automatic grab(output logic [15:0] f, input int nb, input logic inv);
    f = '1;
    while ((tx_pin ^ inv) !== 1'b0) @(posedge pclk);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i <= nb + 1; i++) begin
      f[i] = tx_pin ^ inv;
      repeat (BIT) @(posedge pclk);
    end
  endtask
endmodule

// File: testbench.sv
// self-checking bench for the serial port registers, asynchronous receiver and transmitter
`timescale 1ns/1ps
module testbench;
  import spcs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, txck_in = 1;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_flag, rxdt_in, e, ovr, txck, ckoe, dtoe;
  logic [7:0] r, ctl, d;
  logic [15:0] f;
  logic [9:0] q[$];
  int fails = 0, checks = 0, seed = 32'h83cc1370, cyc = 0;
  spcs_port i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxdt_in(rxdt_in), .rxdt_out(), .rxdt_oe(dtoe), .txck_in(txck_in), .txck_out(txck), .txck_oe(ckoe),
    .rx_flag(rx_flag));
  // divisor 0 with both rate bits set gives a 4-cycle bit
  spcs_peer #(.BIT(4)) i_peer (.pclk(pclk), .tx_pin(txck), .line(rxdt_in));
  initial forever #12.5 pclk = ~pclk;
  // ceiling far above the several hundred cycles the scenarios need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  task complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] x, input logic [7:0] s);
    checks++;
    if (s !== x) begin
      $display("mismatch %s expected %h seen %h", n, x, s);
      fails++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata[7:0];
    e = pslverr;
    if (w && a == SPCS_RXCTL_OFF) ctl = d;
    if (w && a == SPCS_RXCTL_OFF && !d[SPCS_RX_CONTINUOUS_RECEIVE_ENABLE]) ovr = 0;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // model: two-deep buffer of {framing error, ninth bit, data}
  task rx(input logic [8:0] d, input logic stop);
    i_peer.send(d, ctl[SPCS_RX_RX9] ? 9 : 8, stop);
    if (ctl[SPCS_RX_CONTINUOUS_RECEIVE_ENABLE] && !ovr && (!(ctl[SPCS_RX_RX9] && ctl[SPCS_RX_ADDRESS_DETECT_ENABLE]) || d[8])) begin
      if (q.size() == 2) ovr = 1;
      else q.push_back({~stop, d});
    end
  endtask
  task pop();
    chk("rx_flag", 8'(q.size() != 0), {7'h0, rx_flag});
    apb(0, SPCS_RXCTL_OFF, 0);
    chk("rx_status", {ctl[7:3], q[0][9], ovr, q[0][8]}, r);
    apb(0, SPCS_RXDATA_OFF, 0);
    chk("rx_data", 8'(q.pop_front()), r);
  endtask
  initial begin
    ctl = 0;
    ovr = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, SPCS_TXCTL_OFF, 0);
    chk("tx_status", 8'h02, r);
    apb(0, SPCS_BAUD_OFF, 0);
    chk("baud_ctl", 8'h40, r);
    apb(1, SPCS_BAUD_OFF, 8'hec);
    apb(0, SPCS_BAUD_OFF, 0);
    chk("baud_ctl", 8'h48, r);
    apb(0, 8'h1c, 0);
    chk("unmapped_err", 8'h01, {7'h0, e});
    apb(1, SPCS_DIVLO_OFF, 0);
    apb(1, SPCS_TXCTL_OFF, 8'h04);
    apb(1, SPCS_RXCTL_OFF, 8'h90);
    repeat (2) begin
      rx({1'b0, 8'($random(seed))}, 1);
      pop();
    end
    repeat (3) rx({1'b0, 8'($random(seed))}, 1);
    pop();
    pop();
    apb(1, SPCS_RXCTL_OFF, 8'h80);
    apb(0, SPCS_RXCTL_OFF, 0);
    chk("rx_status", 8'h80, r);
    apb(1, SPCS_RXCTL_OFF, 8'h90);
    rx({1'b0, 8'($random(seed))}, 0);
    rx({1'b0, 8'($random(seed))}, 1);
    pop();
    pop();
    apb(1, SPCS_RXCTL_OFF, 8'hd8);
    rx({1'b0, 8'($random(seed))}, 1);
    rx({1'b1, 8'($random(seed))}, 1);
    pop();
    apb(1, SPCS_RXCTL_OFF, 8'h98);
    rx({1'b0, 8'($random(seed))}, 1);
    pop();
    apb(1, SPCS_BAUD_OFF, 8'h0a);
    i_peer.send(9'h000, 8, 1);
    chk("wake_flag", 8'h01, {7'h0, rx_flag});
    apb(0, SPCS_RXDATA_OFF, 0);
    i_peer.blip();
    chk("rx_flag", 8'h00, {7'h0, rx_flag});
    apb(0, SPCS_BAUD_OFF, 0);
    chk("baud_ctl", 8'h48, r);
    apb(1, SPCS_BAUD_OFF, 8'h18);
    apb(1, SPCS_TXCTL_OFF, 8'h65);
    d = 8'($random(seed));
    apb(1, SPCS_TXDATA_OFF, d);
    i_peer.grab(f, 9, 1);
    chk("tx_frame_lo", {d[6:0], 1'b0}, f[7:0]);
    chk("tx_frame_hi", {5'h1f, 1'b1, 1'b1, d[7]}, f[15:8]);
    chk("pin_oe", 8'h01, {6'h0, dtoe, ckoe});
    apb(1, SPCS_TXCTL_OFF, 8'h2c);
    apb(1, SPCS_TXDATA_OFF, d);
    i_peer.grab(f, 12, 1);
    chk("break_lo", 8'h00, f[7:0]);
    chk("break_hi", 8'he0, f[15:8]);
    apb(0, SPCS_TXCTL_OFF, 0);
    chk("tx_status", 8'h26, r);
    complete_run();
  end
endmodule
